// File: ipm_pkg.sv
// Package: register map, field layout, condition codes and helpers for the entry matcher
package ipm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROTO = 8'h04;
  localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
  localparam logic [7:0] OFS_SRC_MASK = 8'h0C;
  localparam logic [7:0] OFS_DST_ADDR = 8'h10;
  localparam logic [7:0] OFS_DST_MASK = 8'h14;
  localparam logic [7:0] OFS_ICMP = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_HIT_CNT = 8'h20;

  // ----------------------------------------------------------------
  // Control word field positions
  // ----------------------------------------------------------------
  localparam int CTRL_FT_LSB = 0;
  localparam int CTRL_PM_LSB = 2;
  localparam int CTRL_TTL_LSB = 5;
  localparam int CTRL_FRAG_LSB = 7;
  localparam int CTRL_OPT_LSB = 9;
  localparam int CTRL_SRC_LSB = 11;
  localparam int CTRL_DST_LSB = 13;
  localparam int CTRL_ITYPE_BIT = 15;
  localparam int CTRL_ICODE_BIT = 16;
  localparam int CTRL_W = 17;
  localparam int ICMP_CODE_LSB = 8;
  localparam int STAT_HIT_BIT = 0;
  localparam int STAT_SEEN_BIT = 1;

  // ----------------------------------------------------------------
  // Condition codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FT_OFF = 2'h0;
  localparam logic [1:0] FT_ANY = 2'h1;
  localparam logic [1:0] FT_IPV4 = 2'h2;
  localparam logic [2:0] PM_ANY = 3'h0;
  localparam logic [2:0] PM_SPEC = 3'h1;
  localparam logic [2:0] PM_ICMP = 3'h2;
  localparam logic [2:0] PM_UDP = 3'h3;
  localparam logic [2:0] PM_TCP = 3'h4;
  localparam logic [1:0] TRI_ANY = 2'h0;
  localparam logic [1:0] TRI_NO = 2'h1;
  localparam logic [1:0] TRI_YES = 2'h2;
  localparam logic [1:0] ADR_ANY = 2'h0;
  localparam logic [1:0] ADR_HOST = 2'h1;
  localparam logic [1:0] ADR_NET = 2'h2;
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;

  // ----------------------------------------------------------------
  // Bus constants and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h00000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} ipm_bus_st_t;

  // Byte compare that a Specific setting enables and Any bypasses
  function automatic logic ipm_spec_ok(input logic spec, input logic [7:0] val,
                                       input logic [7:0] ref_val);
    return !spec || (val == ref_val);
  endfunction

endpackage

// File: ipm_if.sv
// Interfaces carrying one condition between the matcher and its comparators
`timescale 1ns/1ps
interface ipm_addr_if;
  logic [1:0] mode;
  logic [31:0] field;
  logic [31:0] ref_addr;
  logic [31:0] mask;
  logic ok;
  modport src (output mode, output field, output ref_addr, output mask, input ok);
  modport cmp (input mode, input field, input ref_addr, input mask, output ok);
endinterface

interface ipm_flag_if;
  logic [1:0] mode;
  logic flag;
  logic ok;
  modport src (output mode, output flag, input ok);
  modport cmp (input mode, input flag, output ok);
endinterface

// File: ipm_addr_cmp.sv
// Address condition comparator: any, host or masked network compare
`timescale 1ns/1ps
module ipm_addr_cmp (
  ipm_addr_if.cmp c
);
  // Network compare looks only at bits the mask selects; mode 3 acts as any
  always_comb begin
    unique case (c.mode)
      ipm_pkg::ADR_HOST: begin
        c.ok = (c.field == c.ref_addr);
      end
      ipm_pkg::ADR_NET: begin
        c.ok = ((c.field ^ c.ref_addr) & c.mask) == ipm_pkg::WORD_ZERO;
      end
      default: begin
        c.ok = 1'b1;
      end
    endcase
  end
endmodule

// File: ipm_flag_cmp.sv
// Three-way flag condition: no, yes or any
`timescale 1ns/1ps
module ipm_flag_cmp (
  ipm_flag_if.cmp c
);
  // Mode 3 is unused and treated as any, so a stray code never blocks traffic
  always_comb begin
    unique case (c.mode)
      ipm_pkg::TRI_NO: begin
        c.ok = !c.flag;
      end
      ipm_pkg::TRI_YES: begin
        c.ok = c.flag;
      end
      default: begin
        c.ok = 1'b1;
      end
    endcase
  end
endmodule

// File: ipm_top.sv
// Access control entry matcher for IPv4 headers with an AHB-Lite register slave
`timescale 1ns/1ps
// Summary of operation
// - IPv4 header conditions are evaluated only when the entry frame type selects IPv4.
// - With protocol filter Any the protocol field plays no part in the hit.
// - With protocol filter Specific only frames whose protocol equals the 8-bit value hit.
// - ICMP, UDP or TCP filters require that protocol; only ICMP adds its own type and code conditions.
// - TTL zero rejects TTL above zero, non-zero needs TTL above zero, Any ignores it.
// - A frame is fragmented if more-fragments is set or its offset is above zero; No, Yes, Any.
// - Options No rejects frames with options, Yes requires them, Any ignores them.
// - Source address condition is Any, Host compare or masked Network compare.
// - Destination address condition is Any, Host compare or masked Network compare.
// - For ICMP entries a Specific type condition needs the type to equal the value.
// - For ICMP entries a Specific code condition needs the code to equal the value.
module ipm_top (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_frm_valid,
  input wire logic i_frm_is_ipv4,
  input wire logic [7:0] i_frm_proto,
  input wire logic [7:0] i_frm_ttl,
  input wire logic i_frm_more_fragments_bit,
  input wire logic [12:0] i_frm_fragment_position,
  input wire logic i_frm_options,
  input wire logic [31:0] i_frm_src_addr,
  input wire logic [31:0] i_frm_dst_addr,
  input wire logic [7:0] i_frm_icmp_type,
  input wire logic [7:0] i_frm_icmp_code,
  output logic o_hit_valid,
  output logic o_hit
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ipm_pkg::ipm_bus_st_t bus_st, next_bus_st;
  logic [7:0] bus_ofs, next_bus_ofs, proto_val, next_proto_val;
  logic bus_hi_zero, next_bus_hi_zero, bus_wr, next_bus_wr, hreadyout, next_hreadyout;
  logic [31:0] hrdata, next_hrdata, src_addr, next_src_addr, src_mask, next_src_mask;
  logic [31:0] dst_addr, next_dst_addr, dst_mask, next_dst_mask;
  logic [ipm_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [15:0] icmp_val, next_icmp_val, hit_cnt, next_hit_cnt;
  logic hit_valid, next_hit_valid, hit, next_hit, seen, next_seen;
  logic accept, do_write, cnt_clear;
  logic [1:0] ft;
  logic [2:0] pm;
  logic proto_ok, icmp_ok, ip_ok, match;
  ipm_addr_if src_c (), dst_c ();
  ipm_flag_if ttl_c (), frag_c (), opt_c ();

  assign ft = ctrl[ipm_pkg::CTRL_FT_LSB +: 2];
  assign pm = ctrl[ipm_pkg::CTRL_PM_LSB +: 3];

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Every transfer takes one wait state so that reads see writes just before them
  assign accept = i_hsel && i_hready && (i_htrans == ipm_pkg::HTRANS_NONSEQ);
  assign do_write = (bus_st == ipm_pkg::BUS_WAIT) && bus_wr && bus_hi_zero;
  assign cnt_clear = do_write && (bus_ofs == ipm_pkg::OFS_HIT_CNT);

  always_comb begin
    next_bus_st = bus_st;
    next_bus_ofs = bus_ofs;
    next_bus_hi_zero = bus_hi_zero;
    next_bus_wr = bus_wr;
    next_hrdata = hrdata;
    unique case (bus_st)
      ipm_pkg::BUS_WAIT: begin
        next_bus_st = ipm_pkg::BUS_DONE;
        next_hrdata = ipm_pkg::WORD_ZERO;
        if (!bus_wr && bus_hi_zero) begin
          unique case (bus_ofs)
            ipm_pkg::OFS_CTRL: next_hrdata = {15'h0000, ctrl};
            ipm_pkg::OFS_PROTO: next_hrdata = {24'h000000, proto_val};
            ipm_pkg::OFS_SRC_ADDR: next_hrdata = src_addr;
            ipm_pkg::OFS_SRC_MASK: next_hrdata = src_mask;
            ipm_pkg::OFS_DST_ADDR: next_hrdata = dst_addr;
            ipm_pkg::OFS_DST_MASK: next_hrdata = dst_mask;
            ipm_pkg::OFS_ICMP: next_hrdata = {16'h0000, icmp_val};
            ipm_pkg::OFS_STATUS: next_hrdata = {30'h00000000, seen, hit};
            ipm_pkg::OFS_HIT_CNT: next_hrdata = {16'h0000, hit_cnt};
            default: next_hrdata = ipm_pkg::WORD_ZERO;
          endcase
        end
      end
      default: begin
        next_bus_st = ipm_pkg::BUS_IDLE;
      end
    endcase
    if (bus_st != ipm_pkg::BUS_WAIT && accept) begin
      next_bus_st = ipm_pkg::BUS_WAIT;
      next_bus_ofs = i_haddr[7:0];
      next_bus_hi_zero = (i_haddr[31:8] == 24'h000000) && (i_haddr[1:0] == 2'h0);
      next_bus_wr = i_hwrite && (i_hsize == ipm_pkg::HSIZE_WORD);
    end
    next_hreadyout = (next_bus_st != ipm_pkg::BUS_WAIT);
  end

  // Bus state registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_st <= ipm_pkg::BUS_IDLE;
      bus_ofs <= 8'h00;
      bus_hi_zero <= 1'b0;
      bus_wr <= 1'b0;
      hrdata <= ipm_pkg::WORD_ZERO;
      hreadyout <= 1'b1;
    end else begin
      bus_st <= next_bus_st;
      bus_ofs <= next_bus_ofs;
      bus_hi_zero <= next_bus_hi_zero;
      bus_wr <= next_bus_wr;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
    end
  end

  // ----------------------------------------------------------------
  // Entry configuration registers
  // ----------------------------------------------------------------
  // Writes to status or unmapped offsets are dropped; the response stays OKAY
  always_comb begin
    next_ctrl = ctrl;
    next_proto_val = proto_val;
    next_src_addr = src_addr;
    next_src_mask = src_mask;
    next_dst_addr = dst_addr;
    next_dst_mask = dst_mask;
    next_icmp_val = icmp_val;
    if (do_write) begin
      unique case (bus_ofs)
        ipm_pkg::OFS_CTRL: next_ctrl = i_hwdata[ipm_pkg::CTRL_W-1:0];
        ipm_pkg::OFS_PROTO: next_proto_val = i_hwdata[7:0];
        ipm_pkg::OFS_SRC_ADDR: next_src_addr = i_hwdata;
        ipm_pkg::OFS_SRC_MASK: next_src_mask = i_hwdata;
        ipm_pkg::OFS_DST_ADDR: next_dst_addr = i_hwdata;
        ipm_pkg::OFS_DST_MASK: next_dst_mask = i_hwdata;
        ipm_pkg::OFS_ICMP: next_icmp_val = i_hwdata[15:0];
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // Reset leaves the entry off so nothing hits before software sets it up
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= ipm_pkg::CTRL_RST;
      proto_val <= 8'h00;
      src_addr <= ipm_pkg::WORD_ZERO;
      src_mask <= ipm_pkg::WORD_ZERO;
      dst_addr <= ipm_pkg::WORD_ZERO;
      dst_mask <= ipm_pkg::WORD_ZERO;
      icmp_val <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      proto_val <= next_proto_val;
      src_addr <= next_src_addr;
      src_mask <= next_src_mask;
      dst_addr <= next_dst_addr;
      dst_mask <= next_dst_mask;
      icmp_val <= next_icmp_val;
    end
  end

  // ----------------------------------------------------------------
  // Condition comparators
  // ----------------------------------------------------------------
  assign src_c.mode = ctrl[ipm_pkg::CTRL_SRC_LSB +: 2];
  assign src_c.field = i_frm_src_addr;
  assign src_c.ref_addr = src_addr;
  assign src_c.mask = src_mask;
  assign dst_c.mode = ctrl[ipm_pkg::CTRL_DST_LSB +: 2];
  assign dst_c.field = i_frm_dst_addr;
  assign dst_c.ref_addr = dst_addr;
  assign dst_c.mask = dst_mask;
  assign ttl_c.mode = ctrl[ipm_pkg::CTRL_TTL_LSB +: 2];
  assign ttl_c.flag = (i_frm_ttl != 8'h00);
  assign frag_c.mode = ctrl[ipm_pkg::CTRL_FRAG_LSB +: 2];
  assign frag_c.flag = i_frm_more_fragments_bit || (i_frm_fragment_position != 13'h0000);
  assign opt_c.mode = ctrl[ipm_pkg::CTRL_OPT_LSB +: 2];
  assign opt_c.flag = i_frm_options;

  ipm_addr_cmp u_src_cmp (.c(src_c));
  ipm_addr_cmp u_dst_cmp (.c(dst_c));
  ipm_flag_cmp u_ttl_cmp (.c(ttl_c));
  ipm_flag_cmp u_frag_cmp (.c(frag_c));
  ipm_flag_cmp u_opt_cmp (.c(opt_c));

  // Protocol filter; unused codes never hit so a bad setting fails closed
  always_comb begin
    unique case (pm)
      ipm_pkg::PM_ANY: proto_ok = 1'b1;
      ipm_pkg::PM_SPEC: proto_ok = (i_frm_proto == proto_val);
      ipm_pkg::PM_ICMP: proto_ok = (i_frm_proto == ipm_pkg::PROTO_ICMP);
      ipm_pkg::PM_UDP: proto_ok = (i_frm_proto == ipm_pkg::PROTO_UDP);
      ipm_pkg::PM_TCP: proto_ok = (i_frm_proto == ipm_pkg::PROTO_TCP);
      default: proto_ok = 1'b0;
    endcase
  end

  // ICMP extras only count when the entry filters ICMP
  assign icmp_ok = (pm != ipm_pkg::PM_ICMP) ||
                   (ipm_pkg::ipm_spec_ok(ctrl[ipm_pkg::CTRL_ITYPE_BIT], i_frm_icmp_type,
                                         icmp_val[7:0]) &&
                    ipm_pkg::ipm_spec_ok(ctrl[ipm_pkg::CTRL_ICODE_BIT], i_frm_icmp_code,
                                         icmp_val[ipm_pkg::ICMP_CODE_LSB +: 8]));
  assign ip_ok = proto_ok && icmp_ok && ttl_c.ok && frag_c.ok && opt_c.ok &&
                 src_c.ok && dst_c.ok;

  // Frame type gate; other frame types are matched elsewhere, not here
  always_comb begin
    unique case (ft)
      ipm_pkg::FT_ANY: match = 1'b1;
      ipm_pkg::FT_IPV4: match = i_frm_is_ipv4 && ip_ok;
      default: match = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Result and statistics
  // ----------------------------------------------------------------
  // A hit in the cycle the counter is cleared still counts once
  always_comb begin
    next_hit_valid = i_frm_valid;
    next_hit = hit;
    next_seen = seen;
    next_hit_cnt = cnt_clear ? 16'h0000 : hit_cnt;
    if (i_frm_valid) begin
      next_hit = match;
      next_seen = 1'b1;
      if (match) begin
        next_hit_cnt = cnt_clear ? ipm_pkg::CNT_ONE : hit_cnt + ipm_pkg::CNT_ONE;
      end
    end
  end

  // Result registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hit_valid <= 1'b0;
      hit <= 1'b0;
      seen <= 1'b0;
      hit_cnt <= 16'h0000;
    end else begin
      hit_valid <= next_hit_valid;
      hit <= next_hit;
      seen <= next_seen;
      hit_cnt <= next_hit_cnt;
    end
  end

  assign o_hrdata = hrdata;
  assign o_hreadyout = hreadyout;
  assign o_hresp = 1'b0;
  assign o_hit_valid = hit_valid;
  assign o_hit = hit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  property p_ft_gate;
    i_frm_valid && (ft != ipm_pkg::FT_IPV4) |=>
      o_hit_valid && (o_hit == ($past(ft) == ipm_pkg::FT_ANY));
  endproperty
  a_ft_gate: assert property (p_ft_gate) else $error("frame type gate wrong");
  property p_proto_any;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) && (pm == ipm_pkg::PM_ANY) && i_frm_is_ipv4 &&
      ttl_c.ok && frag_c.ok && opt_c.ok && src_c.ok && dst_c.ok |=> o_hit;
  endproperty
  a_proto_any: assert property (p_proto_any) else $error("any protocol blocked");
  property p_proto_spec;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) && (pm == ipm_pkg::PM_SPEC) &&
      (i_frm_proto != proto_val) |=> !o_hit;
  endproperty
  a_proto_spec: assert property (p_proto_spec) else $error("wrong protocol hit");
  property p_proto_tcp;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) && (pm == ipm_pkg::PM_TCP) &&
      (i_frm_proto != ipm_pkg::PROTO_TCP) |=> !o_hit;
  endproperty
  a_proto_tcp: assert property (p_proto_tcp) else $error("non-tcp frame hit");
  property p_ttl;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) && (ttl_c.mode == ipm_pkg::TRI_NO) &&
      (i_frm_ttl != 8'h00) |=> !o_hit;
  endproperty
  a_ttl: assert property (p_ttl) else $error("ttl above zero hit");
  property p_frag;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) && (frag_c.mode == ipm_pkg::TRI_NO) &&
      (i_frm_fragment_position != 13'h0000) |=> !o_hit;
  endproperty
  a_frag: assert property (p_frag) else $error("fragment hit");
  property p_opt;
    (opt_c.mode == ipm_pkg::TRI_YES) && !i_frm_options |-> !opt_c.ok;
  endproperty
  a_opt: assert property (p_opt) else $error("options missing but passed");
  property p_src_host;
    (src_c.mode == ipm_pkg::ADR_HOST) |-> (src_c.ok == (i_frm_src_addr == src_addr));
  endproperty
  a_src_host: assert property (p_src_host) else $error("source host compare");
  property p_dst_net;
    (dst_c.mode == ipm_pkg::ADR_NET) && (((i_frm_dst_addr ^ dst_addr) & dst_mask) == 32'h0)
      |-> dst_c.ok;
  endproperty
  a_dst_net: assert property (p_dst_net) else $error("dest network compare");
  property p_icmp_type;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) && (pm == ipm_pkg::PM_ICMP) &&
      ctrl[ipm_pkg::CTRL_ITYPE_BIT] && (i_frm_icmp_type != icmp_val[7:0]) |=> !o_hit;
  endproperty
  a_icmp_type: assert property (p_icmp_type) else $error("icmp type mismatch hit");
  property p_icmp_code;
    (pm == ipm_pkg::PM_ICMP) && ctrl[ipm_pkg::CTRL_ICODE_BIT] &&
      (i_frm_icmp_code != icmp_val[ipm_pkg::ICMP_CODE_LSB +: 8]) |-> !icmp_ok;
  endproperty
  a_icmp_code: assert property (p_icmp_code) else $error("icmp code mismatch passed");
  property p_all;
    i_frm_valid && (ft == ipm_pkg::FT_IPV4) &&
      !(src_c.ok && dst_c.ok && ttl_c.ok && frag_c.ok && opt_c.ok && i_frm_is_ipv4) |=> !o_hit;
  endproperty
  a_all: assert property (p_all) else $error("hit with a failed condition");

  c_hit: cover property (i_frm_valid && (ft == ipm_pkg::FT_IPV4) ##1 o_hit);
  c_miss: cover property (i_frm_valid && (pm == ipm_pkg::PM_ICMP) ##1 !o_hit);
  c_rd: cover property ((bus_st == ipm_pkg::BUS_WAIT) && !bus_wr ##1 o_hreadyout);

endmodule

// File: ipm_frm_src.sv
// Frame parser stand-in that presents one extracted IPv4 header per pulse
`timescale 1ns/1ps
module ipm_frm_src (
  input wire logic i_mclk,
  output logic o_valid,
  output logic [111:0] o_hdr
);
  // ----------------------------------------------
  // Frame presentation
  // ----------------------------------------------
  // Quiet start before the first header
  initial begin
    o_valid = 1'h0;
    o_hdr = 112'h0;
  end

  // Fields stand for the valid cycle only; afterwards the inverse shows,
  // so a matcher that samples late sees wrong data, not a lucky match
  task automatic send(input logic [111:0] h);
    @(posedge i_mclk);
    o_valid <= 1'h1;
    o_hdr <= h;
    @(posedge i_mclk);
    o_valid <= 1'h0;
    o_hdr <= ~h;
  endtask
endmodule

// File: tb_ipv4_acl_entry_matcher.sv
// Self-checking bench for the IPv4 access control entry matcher
`timescale 1ns/1ps
module tb_ipv4_acl_entry_matcher;
  logic i_mclk;
  logic i_arst_n;
  logic hsel, hwrite, hreadyout, hresp, frm_valid, hit_valid, hit;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [111:0] hdr;
  logic f_v4, f_mf, f_opt, last;
  logic [7:0] f_proto, f_ttl, f_ity, f_ico;
  logic [12:0] f_fpos;
  logic [31:0] f_src, f_dst;
  logic [15:0] hits;
  int err_count;
  int n_checks;

  // ----------------------------------------------
  // Clock, design and parser model
  // ----------------------------------------------
  always #5 i_mclk = ~i_mclk;

  ipm_top u_ipm_top (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_frm_valid(frm_valid), .i_frm_is_ipv4(hdr[111]), .i_frm_proto(hdr[110:103]),
    .i_frm_ttl(hdr[102:95]), .i_frm_more_fragments_bit(hdr[94]),
    .i_frm_fragment_position(hdr[93:81]), .i_frm_options(hdr[80]),
    .i_frm_src_addr(hdr[79:48]), .i_frm_dst_addr(hdr[47:16]),
    .i_frm_icmp_type(hdr[15:8]), .i_frm_icmp_code(hdr[7:0]),
    .o_hit_valid(hit_valid), .o_hit(hit)
  );

  ipm_frm_src u_ipm_frm_src (.i_mclk(i_mclk), .o_valid(frm_valid), .o_hdr(hdr));

  // ----------------------------------------------
  // Verdict, compares and bus cycles
  // ----------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Address phase held until hready is sampled high, then data phase likewise
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge i_mclk);
    htrans <= ipm_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= ipm_pkg::HSIZE_WORD;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (hreadyout !== 1'h1 && n < 20);
      if (n >= 20) begin
        err_count++;
        complete_run();
      end
      if (p == 0) begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    q = hrdata;
    cmp_bit("hresp", 1'h0, hresp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'h1, a, d, q);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'h0, a, 32'h0, q);
    cmp_word(n, e, q);
  endtask

  // Entry control word always selects IPv4 frames; all else defaults to Any
  task automatic cfg(input logic [2:0] pm = 3'h0, input logic [1:0] t = 2'h0,
                     input logic [1:0] fr = 2'h0, input logic [1:0] op = 2'h0,
                     input logic [1:0] s = 2'h0, input logic [1:0] d = 2'h0,
                     input logic [1:0] ic = 2'h0);
    wr(ipm_pkg::OFS_CTRL, {15'h0, ic, d, s, op, fr, t, pm, ipm_pkg::FT_IPV4});
  endtask

  task automatic base();
    {f_v4, f_proto, f_ttl, f_mf, f_fpos, f_opt} = {1'h1, 8'h06, 8'h40, 1'h0, 13'h0, 1'h0};
    {f_src, f_dst, f_ity, f_ico} = {32'h0A000001, 32'hC0A80001, 8'h08, 8'h00};
  endtask

  // One frame, result judged in the cycle the design answers
  task automatic fchk(input logic e);
    u_ipm_frm_src.send({f_v4, f_proto, f_ttl, f_mf, f_fpos, f_opt, f_src, f_dst, f_ity, f_ico});
    #1;
    cmp_bit("hit_valid", 1'h1, hit_valid);
    cmp_bit("hit", e, hit);
    hits = hits + {15'h0, e};
    last = e;
  endtask

  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  task automatic t_reset();
    rchk("ctrl", ipm_pkg::OFS_CTRL, 32'h0);
    rchk("status", ipm_pkg::OFS_STATUS, 32'h0);
    rchk("hit_cnt", ipm_pkg::OFS_HIT_CNT, 32'h0);
    rchk("unmapped", 8'h24, 32'h0);
    base();
    fchk(1'h0);
  endtask

  task automatic t_ftype();
    cfg();
    rchk("ctrl", ipm_pkg::OFS_CTRL, 32'h00000002);
    fchk(1'h1);
    f_v4 = 1'h0;
    fchk(1'h0);
    // Other frame type never hits here; frame type any hits even a non-IPv4 frame
    wr(ipm_pkg::OFS_CTRL, 32'h00000003);
    fchk(1'h0);
    wr(ipm_pkg::OFS_CTRL, {30'h0, ipm_pkg::FT_ANY});
    fchk(1'h1);
    wr(ipm_pkg::OFS_STATUS, 32'h00000000);
    rchk("status", ipm_pkg::OFS_STATUS, 32'h00000003);
    rchk("hit_cnt", ipm_pkg::OFS_HIT_CNT, 32'h00000002);
    wr(ipm_pkg::OFS_HIT_CNT, 32'h00001234);
    hits = 16'h0;
    rchk("hit_cnt", ipm_pkg::OFS_HIT_CNT, 32'h0);
  endtask

  task automatic t_proto();
    logic [7:0] pr[3] = '{ipm_pkg::PROTO_ICMP, ipm_pkg::PROTO_UDP, ipm_pkg::PROTO_TCP};
    base();
    f_proto = 8'hFF;
    cfg(.pm(ipm_pkg::PM_ANY));
    fchk(1'h1);
    cfg(.pm(ipm_pkg::PM_SPEC));
    for (int i = 0; i < 2; i++) begin
      f_proto = i ? 8'hFF : 8'h00;
      wr(ipm_pkg::OFS_PROTO, {24'h0, f_proto});
      fchk(1'h1);
      f_proto = f_proto ^ 8'h01;
      fchk(1'h0);
    end
    for (int i = 0; i < 3; i++) begin
      cfg(.pm(ipm_pkg::PM_ICMP + 3'(i)));
      f_proto = pr[i];
      fchk(1'h1);
      f_proto = pr[(i + 1) % 3];
      fchk(1'h0);
    end
  endtask

  task automatic t_tri();
    base();
    cfg(.t(ipm_pkg::TRI_NO));
    f_ttl = 8'h00;
    fchk(1'h1);
    f_ttl = 8'h01;
    fchk(1'h0);
    cfg(.t(ipm_pkg::TRI_YES));
    fchk(1'h1);
    f_ttl = 8'h00;
    fchk(1'h0);
    cfg(.fr(ipm_pkg::TRI_NO));
    fchk(1'h1);
    f_mf = 1'h1;
    fchk(1'h0);
    {f_mf, f_fpos} = {1'h0, 13'h0001};
    fchk(1'h0);
    cfg(.fr(ipm_pkg::TRI_YES));
    fchk(1'h1);
    f_fpos = 13'h0;
    fchk(1'h0);
    cfg(.op(ipm_pkg::TRI_NO));
    fchk(1'h1);
    f_opt = 1'h1;
    fchk(1'h0);
    cfg(.op(ipm_pkg::TRI_YES));
    fchk(1'h1);
  endtask

  // Other address field stays Any and does not match, so it must be ignored
  task automatic t_addr();
    logic [31:0] a;
    a = 32'hC0A80A05;
    for (int s = 0; s < 2; s++) begin
      base();
      wr(s ? ipm_pkg::OFS_DST_ADDR : ipm_pkg::OFS_SRC_ADDR, a);
      wr(s ? ipm_pkg::OFS_DST_MASK : ipm_pkg::OFS_SRC_MASK, 32'hFFFFFF00);
      for (logic [1:0] m = 2'h1; m < 2'h3; m++) begin
        cfg(.s(s ? 2'h0 : m), .d(s ? m : 2'h0));
        {f_src, f_dst} = s ? {f_src, a} : {a, f_dst};
        fchk(1'h1);
        {f_src, f_dst} = s ? {f_src, a ^ 32'hFF} : {a ^ 32'hFF, f_dst};
        fchk(m == ipm_pkg::ADR_NET);
        {f_src, f_dst} = s ? {f_src, a ^ 32'h100} : {a ^ 32'h100, f_dst};
        fchk(1'h0);
      end
    end
  endtask

  task automatic t_icmp();
    base();
    {f_proto, f_ico} = {ipm_pkg::PROTO_ICMP, 8'h00};
    wr(ipm_pkg::OFS_ICMP, 32'h00000308);
    cfg(.pm(ipm_pkg::PM_ICMP), .ic(2'h1));
    fchk(1'h1);
    f_ity = 8'h09;
    fchk(1'h0);
    cfg(.pm(ipm_pkg::PM_ICMP), .ic(2'h2));
    f_ico = 8'h03;
    fchk(1'h1);
    f_ico = 8'h02;
    fchk(1'h0);
    cfg(.pm(ipm_pkg::PM_ICMP), .ic(2'h3), .t(ipm_pkg::TRI_YES));
    {f_ity, f_ico} = {8'h08, 8'h03};
    fchk(1'h1);
    f_ttl = 8'h00;
    fchk(1'h0);
  endtask

  // Reset, then every scenario, then the counters that the frames left behind
  initial begin
    {i_mclk, i_arst_n, hsel, hwrite, htrans, hsize} = 9'h000;
    {haddr, hwdata, hits, last} = 81'h0;
    err_count = 0;
    n_checks = 0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    hsel <= 1'h1;
    t_reset();
    t_ftype();
    t_proto();
    t_tri();
    t_addr();
    t_icmp();
    rchk("hit_cnt", ipm_pkg::OFS_HIT_CNT, {16'h0, hits});
    rchk("status", ipm_pkg::OFS_STATUS, {30'h0, 1'h1, last});
    complete_run();
  end
endmodule
